// ==== hdl/pbh_pci_port.sv ====
`timescale 1ns/1ps
`include "pbh_defines.svh"
module pbh_pci_port #(
   parameter logic [31:0] TGT_BASE = `PBH_TGT_BASE,
   parameter logic [31:0] TGT_MASK = `PBH_TGT_MASK,
   parameter int          LEN_W    = 8
) (
   // clock and reset
   input  wire logic             CLK,
   input  wire logic             RST,
   // address, data, command, parity
   input  wire logic [31:0]      AD_IN,
   output logic      [31:0]      AD_OUT,
   output logic                  AD_OE_N,
   input  wire logic [3:0]       CBE_N_IN,
   output logic      [3:0]       CBE_N_OUT,
   output logic      [3:0]       CBE_OE_N,
   input  wire logic             PAR_IN,
   output logic                  PAR_OUT,
   output logic                  PAR_OE_N,
   output logic                  PAR_ERR,
   // bus control
   input  wire logic             FRAME_N_IN,
   output logic                  FRAME_N_OUT,
   output logic                  FRAME_N_OE_N,
   input  wire logic             IRDY_N_IN,
   output logic                  IRDY_N_OUT,
   output logic                  IRDY_N_OE_N,
   input  wire logic             TRDY_N_IN,
   output logic                  TRDY_N_OUT,
   output logic                  TRDY_N_OE_N,
   input  wire logic             STOP_N_IN,
   output logic                  STOP_N_OUT,
   output logic                  STOP_N_OE_N,
   input  wire logic             DEVSEL_N_IN,
   output logic                  DEVSEL_N_OUT,
   output logic                  DEVSEL_N_OE_N,
   output logic                  REQ_N,
   input  wire logic             GNT_N,
   // master user side
   input  wire logic             MST_START,
   input  wire logic             MST_WRITE,
   input  wire logic [31:0]      MST_ADDR,
   input  wire logic [3:0]       MST_BE,
   input  wire logic [LEN_W-1:0] MST_LEN,
   input  wire logic [31:0]      MST_WDATA,
   output logic                  MST_BUSY,
   output logic                  MST_WTAKE,
   output logic      [31:0]      MST_RDATA,
   output logic                  MST_RVALID,
   output logic                  MST_DONE,
   output logic                  MST_ABORT,
   // target user side
   output logic      [31:0]      TGT_ADDR,
   output logic                  TGT_WRITE,
   output logic      [3:0]       TGT_BE,
   output logic      [31:0]      TGT_WDATA,
   output logic                  TGT_WVALID,
   output logic                  TGT_RNEXT,
   input  wire logic [31:0]      TGT_RDATA,
   input  wire logic             TGT_STOP
);
   pbh_pkg::pbh_mst_state_t m_state_reg;
   pbh_pkg::pbh_tgt_state_t t_state_reg;
   logic [31:0]      m_ad_reg;
   logic             m_ad_oe_reg;
   logic [3:0]       m_cbe_reg;
   logic             m_oe_reg;
   logic             m_frame_n_reg;
   logic             m_irdy_n_reg;
   logic             req_n_reg;
   logic             m_write_reg;
   logic [LEN_W-1:0] m_cnt_reg;
   logic [2:0]       m_wait_reg;
   logic [31:0]      m_rdata_reg;
   logic             m_rvalid_reg;
   logic             m_done_reg;
   logic             m_abort_reg;
   logic [31:0]      t_ad_reg;
   logic             t_ad_oe_reg;
   logic             t_oe_reg;
   logic             t_devsel_n_reg;
   logic             t_trdy_n_reg;
   logic             t_stop_n_reg;
   logic             t_write_reg;
   logic [31:0]      t_addr_reg;
   logic [31:0]      t_wdata_reg;
   logic [3:0]       t_be_reg;
   logic             t_wvalid_reg;
   logic             frame_q_reg;
   logic             bus_idle;
   logic             m_xfer;
   logic             m_stop;
   logic             m_noclaim;
   logic             t_start;
   logic             t_hit;
   logic             t_xfer;
   logic             t_end;

   pbh_par_if par_bus ();

   pbh_parity u_parity (
      .CLK (CLK),
      .RST (RST),
      .pb  (par_bus.gen)
   );

   assign bus_idle  = FRAME_N_IN && IRDY_N_IN;
   assign m_xfer    = (m_state_reg == pbh_pkg::M_DATA) && !m_irdy_n_reg && !TRDY_N_IN;
   assign m_stop    = (m_state_reg == pbh_pkg::M_DATA) && !STOP_N_IN;
   assign m_noclaim = (m_state_reg == pbh_pkg::M_DATA) && DEVSEL_N_IN
                      && (m_wait_reg == `PBH_DEVSEL_WAIT);

   // master: request, address phase, data phases, turnaround
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         m_state_reg   <= pbh_pkg::M_IDLE;
         req_n_reg     <= 1'b1;
         m_oe_reg      <= 1'b0;
         m_frame_n_reg <= 1'b1;
         m_irdy_n_reg  <= 1'b1;
         m_ad_oe_reg   <= 1'b0;
         m_ad_reg      <= 32'h0000_0000;
         m_cbe_reg     <= 4'hF;
         m_write_reg   <= 1'b0;
         m_cnt_reg     <= '0;
      end else begin
         case (m_state_reg)
            pbh_pkg::M_IDLE: begin
               if (MST_START) begin
                  req_n_reg   <= 1'b0;
                  m_write_reg <= MST_WRITE;
                  m_cnt_reg   <= MST_LEN;
                  m_state_reg <= pbh_pkg::M_REQ;
               end
            end
            pbh_pkg::M_REQ: begin
               if (!GNT_N && bus_idle) begin
                  req_n_reg     <= 1'b1;
                  m_oe_reg      <= 1'b1;
                  m_frame_n_reg <= 1'b0;
                  m_ad_oe_reg   <= 1'b1;
                  m_ad_reg      <= MST_ADDR;
                  m_cbe_reg     <= m_write_reg ? `PBH_CMD_MEM_WR : `PBH_CMD_MEM_RD;
                  m_state_reg   <= pbh_pkg::M_ADDR;
               end
            end
            pbh_pkg::M_ADDR: begin
               m_irdy_n_reg  <= 1'b0;
               m_cbe_reg     <= ~MST_BE;
               m_frame_n_reg <= (m_cnt_reg == LEN_W'(1));
               if (m_write_reg) begin
                  m_ad_reg <= MST_WDATA;
               end else begin
                  m_ad_oe_reg <= 1'b0;
               end
               m_state_reg <= pbh_pkg::M_DATA;
            end
            pbh_pkg::M_DATA: begin
               if (m_noclaim || ((m_xfer || m_stop) && m_frame_n_reg)) begin
                  m_frame_n_reg <= 1'b1;
                  m_irdy_n_reg  <= 1'b1;
                  m_ad_oe_reg   <= 1'b0;
                  m_state_reg   <= pbh_pkg::M_TURN;
               end else if (m_xfer) begin
                  m_cnt_reg     <= m_cnt_reg - LEN_W'(1);
                  m_frame_n_reg <= (m_cnt_reg == LEN_W'(2)) || m_stop;
                  if (m_write_reg) begin
                     m_ad_reg <= MST_WDATA;
                  end
               end else if (m_stop) begin
                  m_frame_n_reg <= 1'b1;
               end
            end
            pbh_pkg::M_TURN: begin
               m_oe_reg    <= 1'b0;
               m_state_reg <= pbh_pkg::M_IDLE;
            end
            default: begin
               m_state_reg <= pbh_pkg::M_IDLE;
            end
         endcase
      end
   end

   // wait for a target to claim the address
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         m_wait_reg <= 3'h0;
      end else if (m_state_reg != pbh_pkg::M_DATA) begin
         m_wait_reg <= 3'h0;
      end else if (DEVSEL_N_IN && (m_wait_reg != `PBH_DEVSEL_WAIT)) begin
         m_wait_reg <= m_wait_reg + 3'h1;
      end
   end

   // master results toward the user
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         m_rdata_reg  <= 32'h0000_0000;
         m_rvalid_reg <= 1'b0;
         m_done_reg   <= 1'b0;
         m_abort_reg  <= 1'b0;
      end else begin
         m_rvalid_reg <= m_xfer && !m_write_reg;
         if (m_xfer && !m_write_reg) begin
            m_rdata_reg <= AD_IN;
         end
         m_abort_reg <= m_noclaim;
         m_done_reg  <= !m_noclaim && (m_xfer || m_stop) && m_frame_n_reg;
      end
   end

   assign MST_WTAKE = m_write_reg && ((m_state_reg == pbh_pkg::M_ADDR)
                      || (m_xfer && !m_frame_n_reg));

   // target: decode on a new frame, claim, move data, release
   assign t_start = frame_q_reg && !FRAME_N_IN && ((m_state_reg == pbh_pkg::M_IDLE)
                    || (m_state_reg == pbh_pkg::M_REQ));
   assign t_hit   = ((AD_IN & TGT_MASK) == TGT_BASE) && ((CBE_N_IN == `PBH_CMD_MEM_RD)
                    || (CBE_N_IN == `PBH_CMD_MEM_WR));
   assign t_xfer  = (t_state_reg == pbh_pkg::T_DATA) && !IRDY_N_IN && !t_trdy_n_reg;
   assign t_end   = FRAME_N_IN && (t_xfer || !t_stop_n_reg);
   assign TGT_RNEXT = !t_write_reg && ((t_state_reg == pbh_pkg::T_CLAIM)
                      || (t_xfer && !FRAME_N_IN));

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         frame_q_reg <= 1'b1;
      end else begin
         frame_q_reg <= FRAME_N_IN;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         t_state_reg    <= pbh_pkg::T_IDLE;
         t_oe_reg       <= 1'b0;
         t_devsel_n_reg <= 1'b1;
         t_trdy_n_reg   <= 1'b1;
         t_stop_n_reg   <= 1'b1;
         t_ad_oe_reg    <= 1'b0;
         t_ad_reg       <= 32'h0000_0000;
         t_write_reg    <= 1'b0;
      end else begin
         case (t_state_reg)
            pbh_pkg::T_IDLE: begin
               if (t_start && t_hit) begin
                  t_oe_reg       <= 1'b1;
                  t_devsel_n_reg <= 1'b0;
                  t_write_reg    <= CBE_N_IN[0];
                  t_state_reg    <= pbh_pkg::T_CLAIM;
               end
            end
            pbh_pkg::T_CLAIM: begin
               t_trdy_n_reg <= 1'b0;
               if (!t_write_reg) begin
                  t_ad_oe_reg <= 1'b1;
                  t_ad_reg    <= TGT_RDATA;
               end
               t_state_reg <= pbh_pkg::T_DATA;
            end
            pbh_pkg::T_DATA: begin
               if (t_end) begin
                  t_devsel_n_reg <= 1'b1;
                  t_trdy_n_reg   <= 1'b1;
                  t_stop_n_reg   <= 1'b1;
                  t_ad_oe_reg    <= 1'b0;
                  t_state_reg    <= pbh_pkg::T_TURN;
               end else begin
                  if (TGT_STOP) begin
                     t_stop_n_reg <= 1'b0;
                  end
                  if (t_xfer && !t_write_reg) begin
                     t_ad_reg <= TGT_RDATA;
                  end
               end
            end
            pbh_pkg::T_TURN: begin
               t_oe_reg    <= 1'b0;
               t_state_reg <= pbh_pkg::T_IDLE;
            end
            default: begin
               t_state_reg <= pbh_pkg::T_IDLE;
            end
         endcase
      end
   end

   // target address and write data toward the user
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         t_addr_reg   <= 32'h0000_0000;
         t_wdata_reg  <= 32'h0000_0000;
         t_be_reg     <= 4'h0;
         t_wvalid_reg <= 1'b0;
      end else begin
         t_wvalid_reg <= t_xfer && t_write_reg;
         if (t_xfer && t_write_reg) begin
            t_wdata_reg <= AD_IN;
            t_be_reg    <= ~CBE_N_IN;
         end
         if ((t_state_reg == pbh_pkg::T_IDLE) && t_start && t_hit) begin
            t_addr_reg <= AD_IN;
         end else if (t_wvalid_reg || TGT_RNEXT) begin
            t_addr_reg <= t_addr_reg + `PBH_ADDR_STEP;
         end
      end
   end

   // parity covers the lines as they stand, driven or received
   assign par_bus.ad     = AD_OE_N ? AD_IN : AD_OUT;
   assign par_bus.cbe    = m_oe_reg ? m_cbe_reg : CBE_N_IN;
   assign par_bus.drive  = !AD_OE_N;
   assign par_bus.chk    = (t_xfer && t_write_reg) || (m_xfer && !m_write_reg)
                           || ((t_state_reg == pbh_pkg::T_IDLE) && t_start && t_hit);
   assign par_bus.par_in = PAR_IN;

   assign AD_OUT        = m_ad_oe_reg ? m_ad_reg : t_ad_reg;
   assign AD_OE_N       = !(m_ad_oe_reg || t_ad_oe_reg);
   assign CBE_N_OUT     = m_cbe_reg;
   assign CBE_OE_N      = {4{!m_oe_reg}};
   assign PAR_OUT       = par_bus.par;
   assign PAR_OE_N      = par_bus.par_oe_n;
   assign PAR_ERR       = par_bus.par_err;
   assign FRAME_N_OUT   = m_frame_n_reg;
   assign FRAME_N_OE_N  = !m_oe_reg;
   assign IRDY_N_OUT    = m_irdy_n_reg;
   assign IRDY_N_OE_N   = !m_oe_reg;
   assign TRDY_N_OUT    = t_trdy_n_reg;
   assign TRDY_N_OE_N   = !t_oe_reg;
   assign STOP_N_OUT    = t_stop_n_reg;
   assign STOP_N_OE_N   = !t_oe_reg;
   assign DEVSEL_N_OUT  = t_devsel_n_reg;
   assign DEVSEL_N_OE_N = !t_oe_reg;
   assign REQ_N         = req_n_reg;
   assign MST_BUSY      = (m_state_reg != pbh_pkg::M_IDLE);
   assign MST_RDATA     = m_rdata_reg;
   assign MST_RVALID    = m_rvalid_reg;
   assign MST_DONE      = m_done_reg;
   assign MST_ABORT     = m_abort_reg;
   assign TGT_ADDR      = t_addr_reg;
   assign TGT_WRITE     = t_write_reg;
   assign TGT_BE        = t_be_reg;
   assign TGT_WDATA     = t_wdata_reg;
   assign TGT_WVALID    = t_wvalid_reg;

   property p_no_grant;
      @(posedge CLK) disable iff (RST)
         (m_state_reg == pbh_pkg::M_REQ) && GNT_N |-> !REQ_N ##1 FRAME_N_OE_N;
   endproperty
   a_no_grant: assert property (p_no_grant) else $error("master started without grant");

   property p_addr_phase;
      @(posedge CLK) disable iff (RST)
         (m_state_reg == pbh_pkg::M_REQ) && !GNT_N && bus_idle
         |=> !FRAME_N_OUT && !FRAME_N_OE_N && !AD_OE_N && (AD_OUT == $past(MST_ADDR));
   endproperty
   a_addr_phase: assert property (p_addr_phase) else $error("address phase not opened");

   property p_frame_last;
      @(posedge CLK) disable iff (RST)
         m_xfer && !m_frame_n_reg && (m_cnt_reg == LEN_W'(2)) |=> FRAME_N_OUT && !IRDY_N_OUT;
   endproperty
   a_frame_last: assert property (p_frame_last) else $error("frame held into last phase");

   property p_irdy;
      @(posedge CLK) disable iff (RST)
         (m_state_reg == pbh_pkg::M_ADDR) |=> !IRDY_N_OUT && !IRDY_N_OE_N;
   endproperty
   a_irdy: assert property (p_irdy) else $error("initiator ready missing in data phase");

   property p_wait_state;
      @(posedge CLK) disable iff (RST)
         (m_state_reg == pbh_pkg::M_DATA) && TRDY_N_IN && STOP_N_IN && !DEVSEL_N_IN
         |=> $stable(m_cnt_reg) && $stable(m_ad_reg) && (m_state_reg == pbh_pkg::M_DATA);
   endproperty
   a_wait_state: assert property (p_wait_state) else $error("phase moved without target ready");

   property p_claim;
      @(posedge CLK) disable iff (RST)
         (t_state_reg == pbh_pkg::T_IDLE) && t_start && t_hit
         |=> !DEVSEL_N_OUT && TRDY_N_OUT ##1 !TRDY_N_OUT;
   endproperty
   a_claim: assert property (p_claim) else $error("decoded address not claimed");

   property p_tgt_write;
      @(posedge CLK) disable iff (RST)
         t_xfer && t_write_reg |=> TGT_WVALID && (TGT_WDATA == $past(AD_IN));
   endproperty
   a_tgt_write: assert property (p_tgt_write) else $error("write word not captured");

   property p_tgt_stop;
      @(posedge CLK) disable iff (RST)
         (t_state_reg == pbh_pkg::T_DATA) && TGT_STOP && !FRAME_N_IN |=> !STOP_N_OUT;
   endproperty
   a_tgt_stop: assert property (p_tgt_stop) else $error("stop not asserted");

   property p_abort;
      @(posedge CLK) disable iff (RST)
         m_noclaim |=> MST_ABORT && (m_state_reg == pbh_pkg::M_TURN);
   endproperty
   a_abort: assert property (p_abort) else $error("unclaimed cycle not aborted");
endmodule

// ==== hdl/pbh_defines.svh ====
`ifndef PBH_DEFINES_SVH
`define PBH_DEFINES_SVH
// Notes on behaviour
// - Reset returns every functional block of the port to its reset state.
// - PAR is even parity over the 32 address/data lines and the 4 command/enable lines.
// - The master drives PAR for address and write data, the target for read data.
// - As master the port pulls the frame line low to open the address phase.
// - As master the port releases the frame line before the final data transfer.
// - As target the port watches the frame line and then decodes the address.
// - As master the port asserts initiator ready when write data is valid or it can take read data.
// - As target the port watches initiator ready to know write data is on the bus.
// - As target the port asserts target ready when read data is valid or it can take write data.
// - As master the port watches target ready to know the target is ready for data.
// - As target the port asserts stop to ask the master to end the transaction.
// - The port claims with device select as target and samples device select as master.
// - The address/data lines carry the address in the first clock and data afterwards.
// - The port requests the bus and starts master work only after the grant is seen low.
`define PBH_CMD_MEM_RD   4'h6
`define PBH_CMD_MEM_WR   4'h7
`define PBH_TGT_BASE     32'h1000_0000
`define PBH_TGT_MASK     32'hFFFF_F000
`define PBH_DEVSEL_WAIT  3'h5
`define PBH_ADDR_STEP    32'h0000_0004
`define PBH_CLK_MHZ      125
`define PBH_RST_HOLD_MS  10
`define PBH_RST_HOLD_CYC (`PBH_RST_HOLD_MS * 1000 * 1000 / 1000 * `PBH_CLK_MHZ)
`endif

// ==== hdl/pbh_pkg.sv ====
package pbh_pkg;
   typedef enum logic [2:0] {
      M_IDLE = 3'b000,
      M_REQ  = 3'b001,
      M_ADDR = 3'b010,
      M_DATA = 3'b011,
      M_TURN = 3'b100
   } pbh_mst_state_t;
   typedef enum logic [1:0] {
      T_IDLE  = 2'b00,
      T_CLAIM = 2'b01,
      T_DATA  = 2'b10,
      T_TURN  = 2'b11
   } pbh_tgt_state_t;
endpackage

// ==== hdl/pbh_par_if.sv ====
`timescale 1ns/1ps
interface pbh_par_if;
   logic [31:0] ad;
   logic [3:0]  cbe;
   logic        drive;
   logic        chk;
   logic        par_in;
   logic        par;
   logic        par_oe_n;
   logic        par_err;
   modport gen (input ad, cbe, drive, chk, par_in, output par, par_oe_n, par_err);
   modport src (output ad, cbe, drive, chk, par_in, input par, par_oe_n, par_err);
endinterface

// ==== hdl/pbh_parity.sv ====
`timescale 1ns/1ps
module pbh_parity (
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // lines to cover
   pbh_par_if.gen   pb
);
   logic par_reg;
   logic oe_n_reg;
   logic chk_reg;
   logic err_reg;

   // parity of whatever sat on the lines, one clock late
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         par_reg  <= 1'b0;
         oe_n_reg <= 1'b1;
         chk_reg  <= 1'b0;
      end else begin
         par_reg  <= ^{pb.ad, pb.cbe};
         oe_n_reg <= ~pb.drive;
         chk_reg  <= pb.chk;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         err_reg <= 1'b0;
      end else begin
         err_reg <= chk_reg && (pb.par_in != par_reg);
      end
   end

   assign pb.par      = par_reg;
   assign pb.par_oe_n = oe_n_reg;
   assign pb.par_err  = err_reg;

   property p_par_even;
      @(posedge CLK) disable iff (RST)
         pb.drive |=> pb.par == ^{$past(pb.ad), $past(pb.cbe)};
   endproperty
   a_par_even: assert property (p_par_even) else $error("parity not even over driven lines");

   property p_par_owner;
      @(posedge CLK) disable iff (RST)
         1'b1 |=> pb.par_oe_n == !$past(pb.drive);
   endproperty
   a_par_owner: assert property (p_par_owner) else $error("parity drive not one clock late");
endmodule

// ==== verif/pbh_pci_agent.sv ====
`timescale 1ns/1ps
module pbh_pci_agent (
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RST,
   // bus lines seen
   input  wire logic [31:0] ad,
   input  wire logic [3:0]  cbe_n,
   input  wire logic        frame_n,
   input  wire logic        irdy_n,
   input  wire logic        req_n,
   // behaviour control
   input  wire logic        claim_en,
   input  wire logic [2:0]  wait_cyc,
   // bus lines driven
   output logic             gnt_n,
   output logic             devsel_n,
   output logic             trdy_n,
   output logic [31:0]      ad_o,
   output logic             ad_oe,
   output logic             par_o,
   output logic             par_oe,
   // stored word and count
   output logic [31:0]      mem,
   output logic [1:0]       wcnt
);
   logic       act;
   logic       wr;
   logic [2:0] cnt;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         {gnt_n, devsel_n, trdy_n} <= 3'h7;
         {ad_oe, par_o, par_oe, act, wr, cnt, wcnt} <= 10'h000;
         ad_o <= 32'h0000_0000;
         mem  <= 32'h0000_0000;
      end else begin
         gnt_n  <= req_n | act;
         par_o  <= ^{ad, cbe_n};
         par_oe <= ad_oe;
         ad_o   <= mem;
         if (!act && !frame_n) begin
            act <= 1'b1;
            wr  <= (cbe_n == 4'h7);
            cnt <= 3'h0;
         end else if (act) begin
            if (cnt != 3'h7) cnt <= cnt + 3'h1;
            devsel_n <= !claim_en;
            trdy_n   <= !(claim_en && cnt >= wait_cyc);
            ad_oe    <= claim_en && !wr;
            if (frame_n && irdy_n) act <= 1'b0;
            if (!irdy_n && !trdy_n) begin
               if (wr) begin
                  mem  <= ad;
                  wcnt <= wcnt + 2'h1;
               end
               if (frame_n) begin
                  {act, ad_oe} <= 2'h0;
                  {devsel_n, trdy_n} <= 2'h3;
               end
            end
         end
      end
   end
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin miscompares++; \
   $display("BAD %s exp %0h got %0h", nm, e, s); end end
module testbench;
   typedef struct packed {logic w; logic [31:0] a; logic [31:0] d; logic [2:0] wt; logic cl;} pbh_row_t;
   logic CLK = 0, RST = 1, MST_START = 0, MST_WRITE = 0, TGT_STOP = 0, cl = 1, ab, tk, pf, pg;
   logic [31:0] MST_ADDR = 0, MST_WDATA = 0, TGT_RDATA = 0, lastw = 0, exp_a, nxt;
   logic [3:0] MST_BE = 4'hF, exp_c;
   logic [7:0] MST_LEN = 8'h01;
   logic [2:0] wt = 0;
   logic [36:0] lst = 0, pv = 0;
   logic [31:0] AD_IN, AD_OUT, TGT_ADDR, TGT_WDATA, MST_RDATA, p_ad, mem;
   logic [3:0] CBE_N_IN, CBE_N_OUT, CBE_OE_N, TGT_BE;
   logic [1:0] wcnt;
   logic AD_OE_N, PAR_IN, PAR_OUT, PAR_OE_N, PAR_ERR, FRAME_N_IN, FRAME_N_OUT, FRAME_N_OE_N;
   logic IRDY_N_IN, IRDY_N_OUT, IRDY_N_OE_N, TRDY_N_IN, TRDY_N_OUT, TRDY_N_OE_N, STOP_N_IN;
   logic STOP_N_OUT, STOP_N_OE_N, DEVSEL_N_IN, DEVSEL_N_OUT, DEVSEL_N_OE_N, REQ_N, GNT_N;
   logic MST_BUSY, MST_WTAKE, MST_RVALID, MST_DONE, MST_ABORT, TGT_WRITE, TGT_WVALID, TGT_RNEXT;
   logic p_dev, p_trdy, p_adoe, p_par, p_paroe;
   logic bf = 1, bi = 1, bm = 0, bao = 0;
   logic [35:0] bd = 0;
   int miscompares = 0, check_count = 0, cyc = 0, left = 0;
   pbh_row_t rows[5] = '{'{1, 32'h0000_1000, 32'hA5A5_0F0F, 0, 1}, '{0, 32'h0000_1000, 0, 0, 1},
      '{1, 32'h2000_0010, 32'h1234_5678, 3, 1}, '{0, 32'h2000_0010, 0, 3, 1},
      '{1, 32'h3000_0000, 32'hFFFF_FFFF, 0, 0}};

   pbh_pci_port i_pbh_pci_port (.*);
   pbh_pci_agent i_pbh_pci_agent (.CLK(CLK), .RST(RST), .ad(AD_IN), .cbe_n(CBE_N_IN),
      .frame_n(FRAME_N_IN), .irdy_n(IRDY_N_IN), .req_n(REQ_N), .claim_en(cl), .wait_cyc(wt),
      .gnt_n(GNT_N), .devsel_n(p_dev), .trdy_n(p_trdy), .ad_o(p_ad), .ad_oe(p_adoe),
      .par_o(p_par), .par_oe(p_paroe), .mem(mem), .wcnt(wcnt));

   // control lines pulled up; released data lines show the inverse of their last level
   // the bench itself plays a master toward the port's target side
   assign FRAME_N_IN  = (FRAME_N_OE_N | FRAME_N_OUT) & bf;
   assign IRDY_N_IN   = (IRDY_N_OE_N | IRDY_N_OUT) & bi;
   assign STOP_N_IN   = STOP_N_OE_N | STOP_N_OUT;
   assign TRDY_N_IN   = (TRDY_N_OE_N | TRDY_N_OUT) & p_trdy;
   assign DEVSEL_N_IN = (DEVSEL_N_OE_N | DEVSEL_N_OUT) & p_dev;
   assign AD_IN    = !AD_OE_N ? AD_OUT : p_adoe ? p_ad : bao ? bd[35:4] : ~lst[36:5];
   assign CBE_N_IN = !CBE_OE_N[0] ? CBE_N_OUT : bm ? bd[3:0] : ~lst[4:1];
   assign PAR_IN   = !PAR_OE_N ? PAR_OUT : p_paroe ? p_par : bm ? ^lst[36:1] : ~lst[0];

   always #4 CLK = ~CLK;
   always @(posedge CLK) lst <= {AD_IN, CBE_N_IN, PAR_IN};
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         end_sim;
      end
   end

   always @(negedge CLK) begin
      if (!PAR_OE_N) `CHK("par", ^pv[36:1], PAR_OUT)
      `CHK("perr", 1'b0, PAR_ERR)
      if (!FRAME_N_IN && pf && !FRAME_N_OE_N) begin
         `CHK("addr", exp_a, AD_IN)
         `CHK("cmd", exp_c, CBE_N_IN)
         `CHK("gnt", 1'b0, pg)
      end
      if (left != 0 && !IRDY_N_IN && !TRDY_N_IN && !IRDY_N_OE_N) begin
         `CHK("frm", left == 1, FRAME_N_IN)
         left--;
      end
      pv = lst;
      pv[36:1] = {AD_IN, CBE_N_IN};
      pf = FRAME_N_IN;
      pg = GNT_N;
   end

   task automatic mop(input logic w, input logic [31:0] a, d0, d1, input logic [7:0] n);
      exp_a = a;
      exp_c = w ? 4'h7 : 4'h6;
      {MST_WRITE, MST_ADDR, MST_LEN, MST_WDATA, nxt} = {w, a, n, d0, d1};
      {left, ab, tk, MST_START} = {n, 3'b001};
      @(negedge CLK) MST_START = 0;
      repeat (80) begin
         @(negedge CLK);
         if (tk) MST_WDATA = nxt;
         tk = MST_WTAKE;
         if (MST_RVALID) `CHK("rdata", lastw, MST_RDATA)
         if (MST_DONE | MST_ABORT) break;
      end
      ab = MST_ABORT;
      repeat (2) @(negedge CLK);
      `CHK("busy", 1'b0, MST_BUSY)
   endtask

   // one target phase; s holds frame low with a master wait so a stop can come
   task automatic tt(input logic w, s, input logic [31:0] a, d);
      {bf, bm, bao, TGT_STOP} = {3'h3, s};
      TGT_RDATA = d;
      bd = {a, 3'h3, w};
      @(negedge CLK) `CHK("rnx", !w, TGT_RNEXT)
      {bf, bi, bao} = {!s, s, w};
      bd = {d, 4'h3};
      @(negedge CLK) `CHK("tsel", 2'h0, {DEVSEL_N_OUT, TRDY_N_OUT})
      if (!w) `CHK("trd", d, AD_IN)
      if (s) begin
         @(negedge CLK) `CHK("stop", 1'b0, STOP_N_OUT)
         {bf, bi} = 2'h2;
      end
      @(negedge CLK) bi = 1;
      `CHK("twv", {w, w, (w ? a : a + 32'h4)}, {TGT_WRITE, TGT_WVALID, TGT_ADDR})
      if (w) `CHK("twd", {d, 4'hC}, {TGT_WDATA, TGT_BE})
      @(negedge CLK) {bm, bao, TGT_STOP} = 3'h0;
   endtask

   task rst_chk;
      `CHK("req", 1'b1, REQ_N)
      `CHK("fo", 1'b1, FRAME_N_OE_N)
      `CHK("ado", 1'b1, AD_OE_N)
      `CHK("po", 1'b1, PAR_OE_N)
      `CHK("bsy", 1'b0, MST_BUSY)
   endtask

   task end_sim;
      if (miscompares == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      // reset held far shorter than the system minimum: the port has no counter for it
      repeat (8) @(negedge CLK);
      rst_chk;
      RST = 0;
      foreach (rows[i]) begin
         {wt, cl} = {rows[i].wt, rows[i].cl};
         mop(rows[i].w, rows[i].a, rows[i].d, 32'h0, 8'h01);
         if (rows[i].w && rows[i].cl) lastw = rows[i].d;
         `CHK("abort", !rows[i].cl, ab)
         `CHK("mem", lastw, mem)
      end
      tt(1, 0, 32'h1000_0040, 32'h7E57_0001);
      tt(0, 0, 32'h1000_0080, 32'h0DD5_EED5);
      tt(1, 1, 32'h1000_00C0, 32'h5700_0003);
      {wt, cl} = 4'h1;
      mop(1, 32'h0000_2000, 32'h0BAD_F00D, 32'hC0DE_7777, 8'h02);
      lastw = 32'hC0DE_7777;
      `CHK("wcnt", 2'h0, wcnt)
      `CHK("burst", lastw, mem)
      mop(0, 32'h0000_2000, 32'h0, 32'h0, 8'h02);
      {MST_WRITE, MST_LEN, MST_START, exp_c} = 14'h2037;
      @(negedge CLK) MST_START = 0;
      repeat (3) @(negedge CLK);
      RST = 1;
      left = 0;
      @(negedge CLK);
      rst_chk;
      RST = 0;
      mop(1, 32'h0000_3000, 32'h5555_AAAA, 32'h0, 8'h01);
      `CHK("post", 32'h5555_AAAA, mem)
      end_sim;
   end
endmodule
